// ==== hw/sarpc_pkg.sv ====
// Package with constants and types of the converter control block
package sarpc_pkg;
    localparam int SARPC_BITS = 16;
    localparam logic [4:0] SARPC_MSB_IDX = 5'h0F;
    localparam logic [15:0] SARPC_RESULT_RST = 16'h0000;
    localparam logic [4:0] SARPC_IDX_RST = 5'h00;
    // Static window after conversion start, for the host side
    localparam int SARPC_CLK_MHZ = 250;
    localparam int SARPC_QUIET_US = 8;
    localparam int SARPC_QUIET_CYC = SARPC_QUIET_US * SARPC_CLK_MHZ;
    typedef enum logic [1:0] {
        SARPC_IDLE,
        SARPC_CONVERT_REQUEST_N,
        SARPC_PWRDN
    } sarpc_state_t;
endpackage

// ==== hw/sarpc_trial.sv ====
// Trial word builder and comparison for one bit decision
`timescale 1ns/100ps
module sarpc_trial
    import sarpc_pkg::*;
(
    input wire logic [15:0] resolved,
    input wire logic [4:0] bit_idx,
    input wire logic [15:0] sample,
    output logic [15:0] next_word
);
    function automatic logic [15:0] sarpc_onehot(input logic [4:0] idx);
        sarpc_onehot = 16'h0001 << idx[3:0];
    endfunction

    wire [15:0] test_bit = sarpc_onehot(bit_idx);
    wire [15:0] trial = resolved | test_bit;
    wire too_high = trial > sample;
    // Drop the tested bit only when the trial overshoots
    assign next_word = too_high ? resolved : trial;
endmodule

// ==== hw/sarpc_ctrl.sv ====
// Conversion sequencing and power-down control of the SAR converter
`timescale 1ns/100ps
module sarpc_ctrl
    import sarpc_pkg::*;
(
    input wire logic clk,
    input wire logic rst_b,
    input wire logic convert_request_n,
    input wire logic power_down_request,
    input wire logic [15:0] sample_in,
    output logic busy_q,
    output logic powered_down_q,
    output logic result_valid_q,
    output logic [15:0] result_q
);
    ////////////////////////////////////////////////////////////////////
    // Request edge detection
    logic convert_request_n_n_q;
    logic pwr_q;
    sarpc_state_t state_q;
    sarpc_state_t state_d;
    logic [15:0] work_q;
    logic [15:0] sample_q;
    logic [4:0] idx_q;
    logic [15:0] next_word;

    wire convert_request_n_fall = convert_request_n_n_q & ~convert_request_n;
    wire pwr_rise = ~pwr_q & power_down_request;
    wire pwr_fall = pwr_q & ~power_down_request;
    // Power-down with convert already low: conversion, then sleep
    wire start_pd = pwr_rise & ~convert_request_n;
    wire start_convert_request_n = convert_request_n_fall | start_pd;
    // Leave sleep only once convert is back high
    wire wake = pwr_fall & convert_request_n;
    wire last_bit = idx_q == SARPC_IDX_RST;

    ////////////////////////////////////////////////////////////////////
    // Sequencer
    always_comb begin
        state_d = state_q;
        case (state_q)
            SARPC_IDLE: begin
                if (start_convert_request_n) begin
                    state_d = SARPC_CONVERT_REQUEST_N;
                end
            end
            SARPC_CONVERT_REQUEST_N: begin
                if (last_bit) begin
                    state_d = power_down_request ? SARPC_PWRDN : SARPC_IDLE;
                end
            end
            SARPC_PWRDN: begin
                if (wake) begin
                    state_d = SARPC_IDLE;
                end
            end
            default: begin
                state_d = SARPC_IDLE;
            end
        endcase
    end

    sarpc_trial sarpc_trial_i (
        .resolved(work_q),
        .bit_idx(idx_q),
        .sample(sample_q),
        .next_word(next_word)
    );

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            convert_request_n_n_q <= 1'b1;
            pwr_q <= 1'b0;
            state_q <= SARPC_IDLE;
        end else begin
            convert_request_n_n_q <= convert_request_n;
            pwr_q <= power_down_request;
            state_q <= state_d;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Datapath, one decision per clock
    // State decodes shared by the output registers and the checks
    function automatic logic in_convert_request_n(input sarpc_state_t s);
        in_convert_request_n = s == SARPC_CONVERT_REQUEST_N;
    endfunction

    function automatic logic in_sleep(input sarpc_state_t s);
        in_sleep = s == SARPC_PWRDN;
    endfunction

    wire idle_start = state_q == SARPC_IDLE && start_convert_request_n;
    wire converting = in_convert_request_n(state_q);
    // Outputs built from the next state so they line up with state_q
    wire busy_d = in_convert_request_n(state_d);
    wire powered_down_d = in_sleep(state_d);

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            work_q <= SARPC_RESULT_RST;
            sample_q <= SARPC_RESULT_RST;
            idx_q <= SARPC_IDX_RST;
        end else if (idle_start) begin
            work_q <= SARPC_RESULT_RST;
            sample_q <= sample_in;
            idx_q <= SARPC_MSB_IDX;
        end else if (converting) begin
            work_q <= next_word;
            idx_q <= idx_q - 5'h01;
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            result_q <= SARPC_RESULT_RST;
            result_valid_q <= 1'b0;
            busy_q <= 1'b0;
            powered_down_q <= 1'b0;
        end else begin
            busy_q <= busy_d;
            powered_down_q <= powered_down_d;
            if (idle_start) begin
                result_valid_q <= 1'b0;
            end else if (converting && last_bit) begin
                // Final decision written straight out
                result_q <= next_word;
                result_valid_q <= 1'b1;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Checks
    convert_request_n_len_a: assert property (@(posedge clk) disable iff (!rst_b)
        $rose(busy_q) |-> busy_q [*8] ##1 busy_q [*8] ##1 !busy_q)
        else $error("conversion not sixteen cycles");
    pd_start_a: assert property (@(posedge clk) disable iff (!rst_b)
        state_q == SARPC_IDLE && pwr_rise && !convert_request_n
        |=> busy_q)
        else $error("power-down with convert low did not convert");
    pd_enter_a: assert property (@(posedge clk) disable iff (!rst_b)
        $fell(busy_q) && $past(power_down_request) |-> powered_down_q)
        else $error("power-down not entered after conversion");
    pd_exit_a: assert property (@(posedge clk) disable iff (!rst_b)
        powered_down_q && wake |=> !powered_down_q)
        else $error("power-down not left");
    pd_hold_a: assert property (@(posedge clk) disable iff (!rst_b)
        powered_down_q && !wake |=> powered_down_q)
        else $error("power-down left without wake order");
    msb_first_a: assert property (@(posedge clk) disable iff (!rst_b)
        idle_start |=> idx_q == SARPC_MSB_IDX && work_q == 16'h0000)
        else $error("conversion did not start at the top bit");
    decide_a: assert property (@(posedge clk) disable iff (!rst_b)
        converting && !last_bit
        |=> work_q[$past(idx_q[3:0])] ==
            ((($past(work_q) | (16'h0001 << $past(idx_q[3:0])))
              <= $past(sample_q))))
        else $error("bit decision wrong");
    hold_res_a: assert property (@(posedge clk) disable iff (!rst_b)
        !busy_q && !idle_start |=> $stable(result_q))
        else $error("result changed outside conversion");
    result_a: assert property (@(posedge clk) disable iff (!rst_b)
        $fell(busy_q) |-> result_valid_q && result_q <= sample_q)
        else $error("result invalid or above sample");

    ////////////////////////////////////////////////////////////////////
    // Checks on start and sequencing
    convert_request_n_go_a: assert property (@(posedge clk) disable iff (!rst_b)
        state_q == SARPC_IDLE && convert_request_n_fall |=> busy_q && !result_valid_q)
        else $error("convert request did not start a conversion");

    cap_in_a: assert property (@(posedge clk) disable iff (!rst_b)
        idle_start |=> sample_q == $past(sample_in))
        else $error("input not captured at conversion start");

    idx_step_a: assert property (@(posedge clk) disable iff (!rst_b)
        converting && !last_bit
        |=> converting && idx_q == $past(idx_q) - 5'h01)
        else $error("decision index did not step down by one");

    lsb_end_a: assert property (@(posedge clk) disable iff (!rst_b)
        converting && last_bit |=> !busy_q)
        else $error("conversion ran past the last bit");

    lsb_dec_a: assert property (@(posedge clk) disable iff (!rst_b)
        converting && last_bit
        |=> result_q[0] ==
            (($past(work_q) | 16'h0001) <= $past(sample_q)))
        else $error("last bit decision wrong");

    ////////////////////////////////////////////////////////////////////
    // Checks on power-down and result
    pd_quiet_a: assert property (@(posedge clk) disable iff (!rst_b)
        powered_down_q |-> !busy_q)
        else $error("converting while powered down");

    pd_entry_a: assert property (@(posedge clk) disable iff (!rst_b)
        $rose(powered_down_q)
        |-> $past(busy_q) && $past(power_down_request))
        else $error("power-down entered without a finished conversion");

    bad_order_a: assert property (@(posedge clk) disable iff (!rst_b)
        state_q == SARPC_IDLE && pwr_rise && convert_request_n
        |=> !busy_q && !powered_down_q)
        else $error("power-down request alone changed state");

    vld_clr_a: assert property (@(posedge clk) disable iff (!rst_b)
        $rose(busy_q) |-> !result_valid_q)
        else $error("old result still marked valid");

    keep_vld_a: assert property (@(posedge clk) disable iff (!rst_b)
        result_valid_q && !idle_start |=> result_valid_q)
        else $error("result valid dropped without a new start");

    exact_res_a: assert property (@(posedge clk) disable iff (!rst_b)
        $fell(busy_q) |-> result_q == sample_q)
        else $error("result differs from the captured input");
endmodule

// ==== verif/sarpc_host.sv ====
// Host model driving the convert and power-down requests
`timescale 1ns/100ps
module sarpc_host (
    output logic convert_request_n,
    output logic power_down_request
);
    initial begin
        convert_request_n = 1'b1;
        power_down_request = 1'b0;
    end
    // No shift clock is modelled, so none toggles
    // Inputs move only when a test step asks
    // Caller orders convert and power-down edges
    task automatic drive(input logic cn, input logic pd);
        convert_request_n = cn;
        power_down_request = pd;
    endtask
endmodule

// ==== verif/test_sar_conversion_power_control.sv ====
// Self-checking bench of the converter control block
`timescale 1ns/100ps
module test_sar_conversion_power_control
    import sarpc_pkg::*;
;
    logic clk = 1'b0;
    logic rst_b = 1'b0;
    logic [15:0] sample_in = 16'h0000;
    logic convert_request_n, power_down_request;
    logic busy_q, powered_down_q, result_valid_q;
    logic [15:0] result_q;
    logic [15:0] codes [5] = '{16'h8000, 16'hFFFF, 16'h0000, 16'h7FFF,
                               16'hA5A5};
    int failures = 0;
    int n_checks = 0;
    always #2 clk = ~clk;
    sarpc_host sarpc_host_i (
        .convert_request_n(convert_request_n),
        .power_down_request(power_down_request)
    );
    sarpc_ctrl sarpc_ctrl_i (
        .clk(clk),
        .rst_b(rst_b),
        .convert_request_n(convert_request_n),
        .power_down_request(power_down_request),
        .sample_in(sample_in),
        .busy_q(busy_q),
        .powered_down_q(powered_down_q),
        .result_valid_q(result_valid_q),
        .result_q(result_q)
    );
    ////////////////////////////////////////////////////////////////////
    task automatic check(input string what, input logic [15:0] seen,
                         input logic [15:0] exp);
        n_checks++;
        if (seen !== exp) begin
            failures++;
            $display("[ERR] %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic finish_test();
        $display("checks %0d failures %0d", n_checks, failures);
        if (failures == 0 && n_checks > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////
    // Input flips after capture, so a late capture shows up
    task automatic convert_request_n_one(input logic [15:0] v);
        @(negedge clk);
        sample_in = v;
        sarpc_host_i.drive(1'b0, 1'b0);
        @(negedge clk);
        sample_in = ~v;
        check("busy_rise", 16'(busy_q), 16'h0001);
        check("valid_drop", 16'(result_valid_q), 16'h0000);
        sarpc_host_i.drive(1'b1, 1'b0);
        repeat (15) @(negedge clk);
        check("busy_last", 16'(busy_q), 16'h0001);
        @(negedge clk);
        check("busy_fall", 16'(busy_q), 16'h0000);
        check("result", result_q, v);
        repeat (3) @(negedge clk);
        check("result_hold", result_q, v);
        check("valid", 16'(result_valid_q), 16'h0001);
        $display("test convert_request_n %h done", v);
    endtask
    task automatic pd_test();
        @(negedge clk);
        sarpc_host_i.drive(1'b0, 1'b0);
        repeat (20) @(negedge clk);
        sample_in = 16'h1234;
        sarpc_host_i.drive(1'b0, 1'b1);
        @(negedge clk);
        sample_in = 16'hEDCB;
        check("pd_busy", 16'(busy_q), 16'h0001);
        repeat (16) @(negedge clk);
        check("pd_result", result_q, 16'h1234);
        check("pd_in", 16'(powered_down_q), 16'h0001);
        sarpc_host_i.drive(1'b1, 1'b1);
        repeat (2) @(negedge clk);
        check("pd_stay", 16'(powered_down_q), 16'h0001);
        sarpc_host_i.drive(1'b1, 1'b0);
        @(negedge clk);
        check("pd_out", 16'(powered_down_q), 16'h0000);
        $display("test power down done");
    endtask
    // Reset in mid conversion; a later start must work as usual
    task automatic reset_mid();
        @(negedge clk);
        sample_in = 16'h0F0F;
        sarpc_host_i.drive(1'b0, 1'b0);
        @(negedge clk);
        sarpc_host_i.drive(1'b1, 1'b0);
        repeat (4) @(negedge clk);
        rst_b = 1'b0;
        #1;
        check("rst_busy", 16'(busy_q), 16'h0000);
        check("rst_valid", 16'(result_valid_q), 16'h0000);
        check("rst_result", result_q, 16'h0000);
        @(negedge clk);
        rst_b = 1'b1;
        convert_request_n_one(16'h0F0F);
        $display("test reset done");
    endtask
    // Wrong order first, then power-down raised mid conversion
    task automatic pd_late();
        @(negedge clk);
        sarpc_host_i.drive(1'b1, 1'b1);
        repeat (2) @(negedge clk);
        check("order_busy", 16'(busy_q), 16'h0000);
        check("order_pd", 16'(powered_down_q), 16'h0000);
        sarpc_host_i.drive(1'b1, 1'b0);
        @(negedge clk);
        sample_in = 16'h00FF;
        sarpc_host_i.drive(1'b0, 1'b0);
        @(negedge clk);
        sample_in = 16'hFF00;
        check("late_busy", 16'(busy_q), 16'h0001);
        sarpc_host_i.drive(1'b0, 1'b1);
        repeat (16) @(negedge clk);
        check("late_end", 16'(busy_q), 16'h0000);
        check("late_result", result_q, 16'h00FF);
        check("late_pd", 16'(powered_down_q), 16'h0001);
        sarpc_host_i.drive(1'b0, 1'b0);
        repeat (2) @(negedge clk);
        check("late_keep", 16'(powered_down_q), 16'h0001);
        sarpc_host_i.drive(1'b1, 1'b1);
        repeat (2) @(negedge clk);
        check("late_keep2", 16'(powered_down_q), 16'h0001);
        check("late_idle", 16'(busy_q), 16'h0000);
        sarpc_host_i.drive(1'b1, 1'b0);
        @(negedge clk);
        check("late_out", 16'(powered_down_q), 16'h0000);
        $display("test late power down done");
    endtask
    ////////////////////////////////////////////////////////////////////
    initial begin
        repeat (20) @(negedge clk);
        rst_b = 1'b1;
        foreach (codes[i]) begin
            convert_request_n_one(codes[i]);
        end
        reset_mid();
        pd_test();
        pd_late();
        finish_test();
    end
    // About 220 cycles expected; generous margin
    initial begin
        #4000;
        failures++;
        finish_test();
    end
endmodule
